/* File: logic/pcb_cfg_regs.sv */
`timescale 1ns/1ps
module pcb_cfg_regs (
  input wire logic clock, // 10 MHz clock
  input wire logic rstn, // Hard reset, synchronous, active low
  input wire logic cfg_read, // Configuration read cycle strobe
  input wire logic cfg_write, // Configuration write cycle strobe
  input wire logic [7:0] cfg_addr, // Configuration header byte offset
  input wire logic [31:0] cfg_wdata, // Configuration write data
  input wire logic [3:0] cfg_be, // Byte enables, active high
  input wire logic [15:0] cmd_reg, // Command register value
  input wire logic cfg_load_enable, // EEPROM configuration loading enabled
  input wire logic sid_load, // EEPROM subsystem identity load strobe
  input wire logic [31:0] sid_load_data, // EEPROM subsystem identity word
  input wire logic mem_req, // Memory space access request
  input wire logic [31:0] mem_addr, // Memory space access address
  output logic [31:0] cfg_rdata, // Configuration read data
  output logic cfg_rvalid, // Read data valid pulse
  output logic cfg_claim, // Offset belongs to this block
  output logic mem_hit_regs, // Access routed to operational registers
  output logic mem_hit_rom, // Access routed to boot ROM
  output logic [11:0] mem_regs_ofs, // Offset within register window
  output logic [15:0] mem_rom_ofs, // Offset within ROM window
  output logic bootrom_decode_on, // Boot ROM decode enable
  output logic [31:0] mem_window_base, // Memory window base register
  output logic [31:0] boot_rom_window, // Boot ROM window register
  output logic [31:0] subsystem_identity // Subsystem identity register
);

  // Byte-lane merge restricted to writable bits
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be,
    input logic [31:0] wmask
  );
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge_bytes = (old_val & ~(lanes & wmask)) | (new_val & lanes & wmask);
  endfunction

  logic [31:0] mem_window_q;
  logic [31:0] mem_window_d;
  logic [31:0] rom_window_q;
  logic [31:0] rom_window_d;
  logic [31:0] sid_q;
  logic [31:0] sid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic claim_q;
  logic hit_regs_q;
  logic hit_rom_q;
  logic [11:0] regs_ofs_q;
  logic [15:0] rom_ofs_q;

  wire logic sel_mem;
  wire logic sel_sid;
  wire logic sel_rom;
  wire logic sel_cap;
  wire logic sel_any;
  wire logic wr_mem;
  wire logic wr_rom;
  wire logic sid_take;
  wire logic [31:0] mem_window_view;
  wire logic [31:0] rom_window_view;
  wire logic [31:0] cap_view;
  wire logic [31:0] read_mux;
  wire logic dec_hit_regs;
  wire logic dec_hit_rom;
  wire logic [11:0] dec_regs_ofs;
  wire logic [15:0] dec_rom_ofs;

  // Configuration offset decode; offsets are dword aligned
  assign sel_mem = cfg_addr[7:2] == pcb_pkg::OFS_MEM_WINDOW_BASE[7:2];
  assign sel_sid = cfg_addr[7:2] == pcb_pkg::OFS_SUBSYSTEM_IDENTITY[7:2];
  assign sel_rom = cfg_addr[7:2] == pcb_pkg::OFS_BOOT_ROM_WINDOW[7:2];
  assign sel_cap = cfg_addr[7:2] == pcb_pkg::OFS_CAPABILITY_LIST_POINTER[7:2];
  assign sel_any = sel_mem || sel_sid || sel_rom || sel_cap;

  assign wr_mem = cfg_write && sel_mem;
  assign wr_rom = cfg_write && sel_rom;

  // Only base bits and the ROM decode enable bit are stored; size and type bits are forced in the read view
  assign mem_window_d = wr_mem ?
    merge_bytes(mem_window_q, cfg_wdata, cfg_be, pcb_pkg::MEM_WINDOW_WRITE_MASK) : mem_window_q;
  assign rom_window_d = wr_rom ?
    merge_bytes(rom_window_q, cfg_wdata, cfg_be, pcb_pkg::ROM_WINDOW_WRITE_MASK) : rom_window_q;

  // Subsystem identity ignores configuration writes
  assign sid_take = sid_load && cfg_load_enable;
  assign sid_d = sid_take ? sid_load_data : sid_q;

  assign mem_window_view = {mem_window_q[31:pcb_pkg::MEM_BASE_LSB], 8'h00, 1'b0, 2'b00, 1'b0};
  assign rom_window_view = {rom_window_q[31:pcb_pkg::ROM_BASE_LSB], 5'h00, 10'h000,
    rom_window_q[pcb_pkg::ROM_DECODE_BIT]};
  assign cap_view = {24'h00_0000, pcb_pkg::FIRST_CAPABILITY_OFFSET};

  // Unclaimed offsets read zero
  assign read_mux = sel_mem ? mem_window_view :
                    sel_sid ? sid_q :
                    sel_rom ? rom_window_view :
                    sel_cap ? cap_view :
                    32'h0000_0000;
  assign rdata_d = cfg_read ? read_mux : rdata_q;

  pcb_window_decode u_decode (
    .mem_addr(mem_addr),
    .mem_req(mem_req),
    .mem_space_respond(cmd_reg[pcb_pkg::CMD_MEM_SPACE_BIT]),
    .mem_window(mem_window_q),
    .rom_window(rom_window_q),
    .hit_regs(dec_hit_regs),
    .hit_rom(dec_hit_rom),
    .regs_ofs(dec_regs_ofs),
    .rom_ofs(dec_rom_ofs)
  );

  // Only hard reset initialises the header registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mem_window_q <= pcb_pkg::RST_MEM_WINDOW_BASE;
      rom_window_q <= pcb_pkg::RST_BOOT_ROM_WINDOW;
      sid_q <= pcb_pkg::RST_SUBSYSTEM_IDENTITY;
    end else begin
      mem_window_q <= mem_window_d;
      rom_window_q <= rom_window_d;
      sid_q <= sid_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= cfg_read;
      claim_q <= (cfg_read || cfg_write) && sel_any;
    end
  end

  // Decoder results registered so outputs come from flops
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hit_regs_q <= 1'b0;
      hit_rom_q <= 1'b0;
      regs_ofs_q <= 12'h000;
      rom_ofs_q <= 16'h0000;
    end else begin
      hit_regs_q <= dec_hit_regs;
      hit_rom_q <= dec_hit_rom;
      regs_ofs_q <= dec_regs_ofs;
      rom_ofs_q <= dec_rom_ofs;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign cfg_claim = claim_q;
  assign mem_hit_regs = hit_regs_q;
  assign mem_hit_rom = hit_rom_q;
  assign mem_regs_ofs = regs_ofs_q;
  assign mem_rom_ofs = rom_ofs_q;
  assign bootrom_decode_on = rom_window_q[pcb_pkg::ROM_DECODE_BIT];
  assign mem_window_base = mem_window_view;
  assign boot_rom_window = rom_window_view;
  assign subsystem_identity = sid_q;

endmodule

/* File: logic/pcb_pkg.sv */
package pcb_pkg;

  // Configuration header offsets (byte addresses)
  localparam logic [7:0] OFS_MEM_WINDOW_BASE = 8'h14;
  localparam logic [7:0] OFS_SUBSYSTEM_IDENTITY = 8'h2c;
  localparam logic [7:0] OFS_BOOT_ROM_WINDOW = 8'h30;
  localparam logic [7:0] OFS_CAPABILITY_LIST_POINTER = 8'h34;

  // Hard reset values
  localparam logic [31:0] RST_MEM_WINDOW_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_SUBSYSTEM_IDENTITY = 32'h0000_0000;
  localparam logic [31:0] RST_BOOT_ROM_WINDOW = 32'h0000_0000;
  localparam logic [31:0] RST_CAPABILITY_LIST_POINTER = 32'h0000_0040;

  // Memory window fields
  localparam int MEM_BASE_LSB = 12;
  localparam int MEM_BASE_W = 20;
  localparam int MEM_OFS_W = 12;
  localparam logic [31:0] MEM_WINDOW_WRITE_MASK = 32'hffff_f000;

  // Boot ROM window fields
  localparam int ROM_BASE_LSB = 16;
  localparam int ROM_BASE_W = 16;
  localparam int ROM_OFS_W = 16;
  localparam int ROM_DECODE_BIT = 0;
  localparam logic [31:0] ROM_WINDOW_WRITE_MASK = 32'hffff_0001;

  // Subsystem identity fields
  localparam int SUB_DEVICE_LSB = 16;
  localparam int SUB_VENDOR_LSB = 0;

  // Capability pointer
  localparam logic [7:0] FIRST_CAPABILITY_OFFSET = 8'h40;

  // Command register memory space enable position
  localparam int CMD_MEM_SPACE_BIT = 1;

endpackage

/* File: logic/pcb_window_decode.sv */
`timescale 1ns/1ps
module pcb_window_decode (
  input wire logic [31:0] mem_addr, // Memory space address
  input wire logic mem_req, // Memory access request
  input wire logic mem_space_respond, // Command register memory enable
  input wire logic [31:0] mem_window, // Memory window base register
  input wire logic [31:0] rom_window, // Boot ROM window register
  output logic hit_regs, // Access hits operational registers
  output logic hit_rom, // Access hits boot ROM
  output logic [pcb_pkg::MEM_OFS_W-1:0] regs_ofs, // Offset inside register window
  output logic [pcb_pkg::ROM_OFS_W-1:0] rom_ofs // Offset inside ROM window
);

  wire logic rom_on;
  wire logic mem_match;
  wire logic rom_match;

  assign rom_on = rom_window[pcb_pkg::ROM_DECODE_BIT];

  assign mem_match = mem_addr[31:pcb_pkg::MEM_BASE_LSB] == mem_window[31:pcb_pkg::MEM_BASE_LSB];
  assign rom_match = mem_addr[31:pcb_pkg::ROM_BASE_LSB] == rom_window[31:pcb_pkg::ROM_BASE_LSB];

  // Shared decoder: ROM decode steals the path from the registers
  assign hit_regs = mem_req && mem_space_respond && mem_match && !rom_on;
  assign hit_rom = mem_req && mem_space_respond && rom_on && rom_match;

  assign regs_ofs = mem_addr[pcb_pkg::MEM_OFS_W-1:0];
  assign rom_ofs = mem_addr[pcb_pkg::ROM_OFS_W-1:0];

endmodule

/* File: test/pcb_cfg_checker.sv */
`timescale 1ns/1ps
module pcb_cfg_checker (
  input wire logic clock, rstn, cfg_read, cfg_write, cfg_load_enable, sid_load, mem_req, // Controls
  input wire logic cfg_rvalid, cfg_claim, mem_hit_regs, mem_hit_rom, bootrom_decode_on, // Answers
  input wire logic [7:0] cfg_addr, // Offset
  input wire logic [3:0] cfg_be, // Byte enables
  input wire logic [15:0] cmd_reg, // Command
  input wire logic [31:0] cfg_wdata, sid_load_data, mem_addr, cfg_rdata, // Data
  input wire logic [31:0] mem_window_base, boot_rom_window, subsystem_identity // Registers
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire wr_mem = cfg_write && cfg_addr[7:2] == 6'h05 && cfg_be == 4'hf;
  sequence s_cap_rd; cfg_read && cfg_addr[7:2] == 6'h0d; endsequence
  sequence s_reg_hit; mem_req && cmd_reg[1] && !cfg_write && !bootrom_decode_on
    && mem_addr[31:12] == mem_window_base[31:12]; endsequence
  property p_cap; s_cap_rd |=> cfg_rvalid && cfg_rdata == 32'h0000_0040; endproperty
  property p_claim; (cfg_read || cfg_write) && cfg_addr[7:2] == 6'h05 |=> cfg_claim; endproperty
  property p_memwr; wr_mem |=> mem_window_base[31:12] == $past(cfg_wdata[31:12]); endproperty
  property p_memlow; mem_window_base[11:0] == 12'h000; endproperty
  property p_romlow; boot_rom_window[15:1] == 15'h0000 && bootrom_decode_on == boot_rom_window[0]; endproperty
  property p_hit; s_reg_hit |=> mem_hit_regs && !mem_hit_rom; endproperty
  property p_romblk; mem_req && bootrom_decode_on |=> !mem_hit_regs; endproperty
  property p_off; mem_req && !cmd_reg[1] |=> !mem_hit_regs && !mem_hit_rom; endproperty
  property p_sidro; !sid_load |=> $stable(subsystem_identity); endproperty
  property p_sidld; sid_load && cfg_load_enable |=> subsystem_identity == $past(sid_load_data); endproperty
  a_cap: assert property (p_cap) else $error("capability read wrong");
  a_claim: assert property (p_claim) else $error("claim missing");
  a_memwr: assert property (p_memwr) else $error("memory base not written");
  a_memlow: assert property (p_memlow) else $error("memory low bits not zero");
  a_romlow: assert property (p_romlow) else $error("rom low bits wrong");
  a_hit: assert property (p_hit) else $error("register hit missing");
  a_romblk: assert property (p_romblk) else $error("register hit with rom on");
  a_off: assert property (p_off) else $error("hit with memory disabled");
  a_sidro: assert property (p_sidro) else $error("identity changed");
  a_sidld: assert property (p_sidld) else $error("identity not loaded");
endmodule

/* File: test/pcb_host_model.sv */
`timescale 1ns/1ps
module pcb_host_model (
  input wire logic clock, // Bus clock
  input wire logic [31:0] cfg_rdata, // Read answer
  input wire logic cfg_rvalid, // Read answer valid
  output logic cfg_read, // Read strobe
  output logic cfg_write, // Write strobe
  output logic [7:0] cfg_addr, // Header offset
  output logic [31:0] cfg_wdata, // Write data
  output logic [3:0] cfg_be // Byte enables
);
  initial begin
    cfg_read = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    cfg_be = 4'h0;
  end
  // One strobe cycle, held through the sampling edge, then released with scrambled lines
  task automatic go(input logic r, w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    #1 cfg_read = r;
    cfg_write = w;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    @(posedge clock);
    #1 cfg_read = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    go(1'b1, 1'b0, a, 32'h0000_0000, 4'hf);
    d = cfg_rvalid ? cfg_rdata : ~cfg_rdata;
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0, rstn = 1'b0, cfg_load_enable = 1'b0, sid_load = 1'b0, mem_req = 1'b0;
  logic [15:0] cmd_reg = 16'h0000;
  logic [31:0] sid_load_data = 32'h0000_0000, mem_addr = 32'h0000_0000;
  logic cfg_read, cfg_write, cfg_rvalid, cfg_claim, mem_hit_regs, mem_hit_rom, bootrom_decode_on;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [11:0] mem_regs_ofs;
  logic [15:0] mem_rom_ofs;
  logic [31:0] cfg_wdata, cfg_rdata, mem_window_base, boot_rom_window, subsystem_identity;
  int mismatches = 0, tests_run = 0;
  always #50 clock = ~clock;
  pcb_cfg_regs u_dut (.*);
  pcb_host_model u_host (.*);
  task end_of_test;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task mem_chk(input logic [31:0] a, input logic [1:0] e);
    @(posedge clock);
    #1 mem_req = 1'b1;
    mem_addr = a;
    @(posedge clock);
    #1 mem_req = 1'b0;
    mem_addr = ~a;
    chk({30'h0, mem_hit_rom, mem_hit_regs}, {30'h0, e});
  endtask
  task hard_reset;
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
  endtask
  task sid_pulse(input logic en);
    @(posedge clock);
    #1 cfg_load_enable = en;
    sid_load = 1'b1;
    @(posedge clock);
    #1 sid_load = 1'b0;
  endtask
  task t_reset;
    rd_chk(8'h14, 32'h0000_0000);
    rd_chk(8'h30, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0040);
    rd_chk(8'h10, 32'h0000_0000);
    chk({31'h0, cfg_claim}, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0040);
    chk({31'h0, cfg_claim}, 32'h0000_0001);
    $display("test reset done");
  endtask
  task t_mem;
    u_host.go(1'b0, 1'b1, 8'h14, 32'hffff_ffff, 4'hf);
    rd_chk(8'h14, 32'hffff_f000);
    u_host.go(1'b0, 1'b1, 8'h14, 32'h1234_5678, 4'hf);
    u_host.go(1'b0, 1'b1, 8'h14, 32'hffff_ffff, 4'h1);
    rd_chk(8'h14, 32'h1234_5000);
    cmd_reg = 16'h0002;
    mem_chk(32'h1234_5010, 2'b01);
    chk({20'h0, mem_regs_ofs}, 32'h0000_0010);
    mem_chk(32'h1234_6010, 2'b00);
    cmd_reg = 16'h0000;
    mem_chk(32'h1234_5010, 2'b00);
    $display("test memory window done");
  endtask
  task t_rom;
    cmd_reg = 16'h0002;
    u_host.go(1'b0, 1'b1, 8'h30, 32'hffff_ffff, 4'hf);
    rd_chk(8'h30, 32'hffff_0001);
    mem_chk(32'hffff_0020, 2'b10);
    chk({16'h0, mem_rom_ofs}, 32'h0000_0020);
    mem_chk(32'h1234_5010, 2'b00);
    u_host.go(1'b0, 1'b1, 8'h30, 32'h0000_0000, 4'hf);
    mem_chk(32'h1234_5010, 2'b01);
    u_host.go(1'b0, 1'b1, 8'h2c, 32'hffff_ffff, 4'hf);
    u_host.go(1'b0, 1'b1, 8'h34, 32'hffff_ffff, 4'hf);
    rd_chk(8'h2c, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0040);
    $display("test boot rom and read-only done");
  endtask
  task t_sid;
    sid_load_data = 32'habcd_1234;
    sid_pulse(1'b0);
    rd_chk(8'h2c, 32'h0000_0000);
    sid_pulse(1'b1);
    rd_chk(8'h2c, 32'habcd_1234);
    hard_reset;
    rd_chk(8'h2c, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
    $display("test identity and reset done");
  endtask
  initial begin
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    t_reset;
    t_mem;
    t_rom;
    t_sid;
    end_of_test;
  end
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end
endmodule
bind pcb_cfg_regs pcb_cfg_checker u_chk (.*);
